// [adc_sequencer.sv]
// sequencer, result buffering, handshake and temperature loop of the monitor adc
//
// Summary of operation
// R1: config bit 13 picks direct or auto style; auto after reset.
// R2: direct style converts each enabled channel once per trigger, then waits.
// R3: auto style converts enabled channels in turn and restarts endlessly.
// R4: trigger, style change or enable rewrite aborts; a trigger then starts afresh.
// R5: trigger written with direct-to-auto switch stops and waits for a trigger.
// R6: host keeps serial clock quiet during a conversion after it starts.
// R7: eight ten-bit straight binary results, one register per channel.
// R8: each result goes to a holding stage; last channel copies all together.
// R9: no result register changes while a result is being shifted out.
// R10: config bits 9:8 set acquisition time; conversion time fixed.
// R11: any rate code but 00 naps the converter between conversions.
// R12: per-channel rate is programmed rate over number of enabled channels.
// R13: direct style paced by triggers; auto style paced by rate field.
// R14: trigger waits a synchronising delay before the first conversion.
// R15: data-valid pin is open-drain and active low.
// R16: direct style sets ready bit 7 and pulls data-valid low on update.
// R17: ready and data-valid clear after a result read or a trigger write.
// R18: auto style pulses data-valid low for 1 us per update; trigger reads zero.
// R19: temperature enable bit 3 cleared stops temperature conversions.
// R20: temperature conversion runs continuously, restarting after each finish.
// R21: temperature result is 12-bit twos complement in eighth degrees.
// R22: temperature result stays frozen while it is shifted out.
// R23: trigger bit write restarts the sequence at first enabled channel.
// R24: primary converter runs only while power bit 14 is set.
// R25: enabled channels convert in ascending order, disabled ones skipped.
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ns
module adc_sequencer (
   input wire logic clk, // 100 MHz clock
   input wire logic rst, // asynchronous reset, active high
   input wire logic ce, // clock enable, freezes all state when low
   input wire adc_seq_pkg::bus_req_t bus_req, // register strobes, address, write data
   output logic [adc_seq_pkg::DATA_W-1:0] rdata, // read data, cycle after read strobe
   input wire logic [adc_seq_pkg::RES_W-1:0] conv_data, // sar result at end of conversion
   output adc_seq_pkg::adc_ctl_t adc_ctl, // converter control
   input wire logic adc_shift_busy, // a channel result is being shifted out
   input wire logic temp_shift_busy, // temperature result is being shifted out
   output logic temp_start, // start one temperature conversion
   input wire logic temp_done, // temperature conversion finished
   input wire logic [adc_seq_pkg::TEMP_W-1:0] temp_code, // temperature result
   input wire logic data_valid_n_i, // level seen on the data-valid pin
   output logic data_valid_n_o, // data-valid pin drive value
   output logic data_valid_n_oe // data-valid pin pulled low while high
);
   adc_seq_pkg::state_t q;
   adc_seq_pkg::state_t n;

   logic wr_cfg;
   logic trig;
   logic mode_chg;
   logic to_auto_trig;
   logic abort;
   logic rd_data;
   logic do_copy;
   logic [4:0] first_hit;
   logic [4:0] next_hit;

   // lowest enabled channel at or above start; bit 4 set when found
   function automatic logic [4:0] find_en(input logic [adc_seq_pkg::NCH-1:0] en,
                                          input logic [3:0] start);
      logic [4:0] r;
      r = '0;
      for (int i = adc_seq_pkg::NCH - 1; i >= 0; i--) begin
         if (en[i] && (4'(i) >= start)) begin
            r = {1'b1, 1'b0, 3'(i)};
         end
      end
      return r;
   endfunction : find_en

   function automatic logic [adc_seq_pkg::CNT_W-1:0] acq_cycles(input logic [1:0] rate);
      logic [adc_seq_pkg::CNT_W-1:0] r;
      case (rate)
         2'h0: r = adc_seq_pkg::ACQ0_CYC;
         2'h1: r = adc_seq_pkg::ACQ1_CYC;
         2'h2: r = adc_seq_pkg::ACQ2_CYC;
         default: r = adc_seq_pkg::ACQ3_CYC;
      endcase
      return r;
   endfunction : acq_cycles

   assign wr_cfg = bus_req.we && (bus_req.addr == adc_seq_pkg::CFG_ADDR);
   assign trig = wr_cfg && bus_req.wdata[adc_seq_pkg::TRIG_BIT];
   assign mode_chg = wr_cfg && (bus_req.wdata[adc_seq_pkg::MODE_BIT] != q.mode);
   assign to_auto_trig = trig && mode_chg && (q.mode == adc_seq_pkg::MODE_DIRECT);
   assign abort = trig || mode_chg || (bus_req.we && (bus_req.addr == adc_seq_pkg::EN_ADDR));
   assign rd_data = bus_req.re
      && (bus_req.addr[adc_seq_pkg::ADDR_W-1:adc_seq_pkg::CH_W]
          == adc_seq_pkg::DATA_BASE[adc_seq_pkg::ADDR_W-1:adc_seq_pkg::CH_W]);
   assign do_copy = q.copy_pend && !adc_shift_busy; // R9
   assign first_hit = find_en(q.en, 4'h0); // R25
   assign next_hit = find_en(q.en, {1'b0, q.ch} + 4'h1); // R25

   always_comb begin
      n = q;
      n.temp_start = 1'b0;
      n.rdata = '0;

      // register writes
      if (bus_req.we) begin
         case (bus_req.addr)
            adc_seq_pkg::CFG_ADDR: begin
               n.mode = bus_req.wdata[adc_seq_pkg::MODE_BIT]; // R1
               n.rate = bus_req.wdata[adc_seq_pkg::RATE_LO +: 2]; // R10
            end
            adc_seq_pkg::EN_ADDR: n.en = bus_req.wdata[adc_seq_pkg::NCH-1:0];
            adc_seq_pkg::PWR_ADDR: n.adc_on = bus_req.wdata[adc_seq_pkg::ADC_ON_BIT];
            adc_seq_pkg::TCFG_ADDR: n.temp_en = bus_req.wdata[adc_seq_pkg::TEMP_EN_BIT];
            default: ;
         endcase
      end

      // sequencer
      case (q.st)
         adc_seq_pkg::S_WAIT: ;
         adc_seq_pkg::S_SYNC: begin
            if (q.cnt == '0) begin // R14
               if (first_hit[4]) begin
                  n.st = adc_seq_pkg::S_ACQ;
                  n.ch = first_hit[2:0];
                  n.cnt = acq_cycles(q.rate) - 1'b1; // R10
               end else begin
                  n.st = adc_seq_pkg::S_WAIT;
               end
            end else begin
               n.cnt = q.cnt - 1'b1;
            end
         end
         adc_seq_pkg::S_ACQ: begin
            if (q.cnt == '0) begin
               n.st = adc_seq_pkg::S_CONV;
               n.cnt = adc_seq_pkg::CONV_CYC - 1'b1; // R10
            end else begin
               n.cnt = q.cnt - 1'b1;
            end
         end
         adc_seq_pkg::S_CONV: begin
            if (q.cnt == '0) begin
               n.tmpry[q.ch] = conv_data; // R7 R8
               if (next_hit[4]) begin
                  n.st = adc_seq_pkg::S_ACQ; // R12 R25
                  n.ch = next_hit[2:0];
                  n.cnt = acq_cycles(q.rate) - 1'b1;
               end else begin
                  n.copy_pend = 1'b1; // R8
                  if (q.mode == adc_seq_pkg::MODE_DIRECT) begin
                     n.st = adc_seq_pkg::S_WAIT; // R2 R13
                  end else if (first_hit[4]) begin
                     n.st = adc_seq_pkg::S_ACQ; // R3 R13
                     n.ch = first_hit[2:0];
                     n.cnt = acq_cycles(q.rate) - 1'b1;
                  end else begin
                     n.st = adc_seq_pkg::S_WAIT;
                  end
               end
            end else begin
               n.cnt = q.cnt - 1'b1;
            end
         end
         default: n.st = adc_seq_pkg::S_WAIT;
      endcase

      if (abort) begin
         n.st = adc_seq_pkg::S_WAIT; // R4
         if (trig && !to_auto_trig) begin
            n.st = adc_seq_pkg::S_SYNC; // R4 R5 R23
            n.cnt = adc_seq_pkg::SYNC_CYC - 1'b1; // R14
         end
      end
      if (!q.adc_on) begin
         n.st = adc_seq_pkg::S_WAIT; // R24
      end

      // result copy and handshake; a copy outranks a clearing read
      if (rd_data || trig) begin
         n.ready = 1'b0; // R17
      end
      if (do_copy) begin
         n.data = q.tmpry; // R8
         n.copy_pend = 1'b0;
         if (q.mode == adc_seq_pkg::MODE_DIRECT) begin
            n.ready = 1'b1; // R16
         end else begin
            n.pulse_cnt = adc_seq_pkg::PULSE_CYC; // R18
         end
      end else if (q.pulse_cnt != '0) begin
         n.pulse_cnt = q.pulse_cnt - 1'b1;
      end

      // background temperature loop
      if (!q.temp_en) begin
         n.temp_run = 1'b0; // R19
      end else if (!q.temp_run) begin
         n.temp_start = 1'b1; // R20
         n.temp_run = 1'b1;
      end else if (temp_done) begin
         n.temp_hold = temp_code; // R21
         n.temp_pend = 1'b1;
         n.temp_run = 1'b0; // R20
      end
      if (q.temp_pend && !temp_shift_busy) begin
         n.temp_data = q.temp_hold; // R22
         n.temp_pend = 1'b0;
      end

      // register reads; the trigger bit always reads zero
      if (bus_req.re) begin
         if (rd_data) begin
            n.rdata[adc_seq_pkg::RES_W-1:0] = q.data[bus_req.addr[adc_seq_pkg::CH_W-1:0]]; // R7
         end else begin
            case (bus_req.addr)
               adc_seq_pkg::CFG_ADDR: begin
                  n.rdata[adc_seq_pkg::MODE_BIT] = q.mode;
                  n.rdata[adc_seq_pkg::RATE_LO +: 2] = q.rate;
                  n.rdata[adc_seq_pkg::READY_BIT] = q.ready; // R16
                  n.rdata[adc_seq_pkg::PIN_BIT] = data_valid_n_i;
               end
               adc_seq_pkg::EN_ADDR: n.rdata[adc_seq_pkg::NCH-1:0] = q.en;
               adc_seq_pkg::PWR_ADDR: n.rdata[adc_seq_pkg::ADC_ON_BIT] = q.adc_on;
               adc_seq_pkg::TCFG_ADDR: n.rdata[adc_seq_pkg::TEMP_EN_BIT] = q.temp_en;
               adc_seq_pkg::TDATA_ADDR: n.rdata[adc_seq_pkg::TEMP_W-1:0] = q.temp_data;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= adc_seq_pkg::ST_RST;
      end else if (ce) begin
         q <= n;
      end
   end

   assign rdata = q.rdata;
   assign temp_start = q.temp_start;
   assign adc_ctl.pd = !q.adc_on; // R24
   assign adc_ctl.track = (q.st == adc_seq_pkg::S_ACQ);
   assign adc_ctl.convert = (q.st == adc_seq_pkg::S_CONV);
   assign adc_ctl.ch = q.ch;
   // nap until the last fastest-rate acquisition window before each conversion
   assign adc_ctl.nap = q.adc_on && (q.rate != 2'h0) && (q.st != adc_seq_pkg::S_CONV)
      && !((q.st == adc_seq_pkg::S_ACQ) && (q.cnt < adc_seq_pkg::ACQ0_CYC)); // R11
   assign data_valid_n_o = 1'b0; // R15
   assign data_valid_n_oe = q.ready || (q.pulse_cnt != '0); // R15 R16 R18

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   trig_restart_a: assert property ( // R4
      (ce && trig && !to_auto_trig && q.adc_on) |=> (q.st == adc_seq_pkg::S_SYNC)
      && (q.cnt == adc_seq_pkg::SYNC_CYC - 1'b1))
      else $error("trigger did not restart the sequence");
   auto_switch_a: assert property ( // R5
      (ce && to_auto_trig) |=> (q.st == adc_seq_pkg::S_WAIT) && q.mode)
      else $error("trigger during switch to auto did not stop");
   ready_set_a: assert property ( // R16
      (ce && do_copy && (q.mode == adc_seq_pkg::MODE_DIRECT)) |=> q.ready && data_valid_n_oe)
      else $error("ready not set after direct update");
   ready_clear_a: assert property ( // R17
      (ce && (rd_data || trig) && !do_copy) |=> !q.ready)
      else $error("ready not cleared by read or trigger");
   pulse_width_a: assert property ( // R18
      (ce && do_copy && q.mode && !q.ready) |=> (data_valid_n_oe[*8]))
      else $error("auto data-valid pulse too short");
   results_hold_a: assert property ( // R9
      adc_shift_busy |=> $stable(q.data))
      else $error("result registers changed during shift");
   temp_freeze_a: assert property ( // R22
      temp_shift_busy |=> $stable(q.temp_data))
      else $error("temperature result changed during shift");
   power_off_a: assert property ( // R24
      (ce && !q.adc_on) |=> (q.st == adc_seq_pkg::S_WAIT) && !adc_ctl.convert)
      else $error("converter ran while powered down");
   temp_loop_a: assert property ( // R20
      (ce && q.temp_en && q.temp_run && temp_done) ##1 (ce && q.temp_en) |=> temp_start)
      else $error("temperature loop did not restart");
   temp_off_a: assert property ( // R19
      !q.temp_en |=> !temp_start)
      else $error("temperature started while disabled");

   // register writes land at the edge that takes them
   mode_write_a: assert property ( // R1
      (ce && wr_cfg) |=> (q.mode == $past(bus_req.wdata[adc_seq_pkg::MODE_BIT])))
      else $error("mode bit not written");

   rate_write_a: assert property ( // R10
      (ce && wr_cfg) |=> (q.rate == $past(bus_req.wdata[adc_seq_pkg::RATE_LO +: 2])))
      else $error("rate field not written");

   power_write_a: assert property ( // R24
      (ce && bus_req.we && (bus_req.addr == adc_seq_pkg::PWR_ADDR))
      |=> (q.adc_on == $past(bus_req.wdata[adc_seq_pkg::ADC_ON_BIT])))
      else $error("power bit not written");

   temp_en_write_a: assert property ( // R19
      (ce && bus_req.we && (bus_req.addr == adc_seq_pkg::TCFG_ADDR))
      |=> (q.temp_en == $past(bus_req.wdata[adc_seq_pkg::TEMP_EN_BIT])))
      else $error("temperature enable not written");

   // aborts and sequencing
   en_abort_a: assert property ( // R4
      (ce && bus_req.we && (bus_req.addr == adc_seq_pkg::EN_ADDR)) |=> (q.st == adc_seq_pkg::S_WAIT))
      else $error("enable rewrite did not abort");

   mode_abort_a: assert property ( // R4
      (ce && mode_chg && !trig) |=> (q.st == adc_seq_pkg::S_WAIT))
      else $error("style change did not abort");

   direct_idle_a: assert property ( // R2
      (ce && !abort && (q.st == adc_seq_pkg::S_CONV) && (q.cnt == '0) && !next_hit[4]
       && (q.mode == adc_seq_pkg::MODE_DIRECT)) |=> (q.st == adc_seq_pkg::S_WAIT))
      else $error("direct style did not go idle");

   auto_again_a: assert property ( // R3
      (ce && !abort && q.adc_on && (q.st == adc_seq_pkg::S_CONV) && (q.cnt == '0)
       && !next_hit[4] && q.mode && first_hit[4])
      |=> (q.st == adc_seq_pkg::S_ACQ) && (q.ch == $past(first_hit[2:0])))
      else $error("auto style did not restart");

   next_channel_a: assert property ( // R25
      (ce && !abort && q.adc_on && (q.st == adc_seq_pkg::S_CONV) && (q.cnt == '0) && next_hit[4])
      |=> (q.st == adc_seq_pkg::S_ACQ) && (q.ch == $past(next_hit[2:0])) && (q.ch > $past(q.ch)))
      else $error("channel order broken");

   sync_count_a: assert property ( // R14
      (ce && !abort && q.adc_on && (q.st == adc_seq_pkg::S_SYNC) && (q.cnt != '0))
      |=> (q.st == adc_seq_pkg::S_SYNC) && (q.cnt == $past(q.cnt) - 1'b1))
      else $error("sync delay miscounted");

   acq_start_a: assert property ( // R10
      (ce && !abort && q.adc_on && (q.st == adc_seq_pkg::S_SYNC) && (q.cnt == '0) && first_hit[4])
      |=> (q.st == adc_seq_pkg::S_ACQ) && (q.cnt == acq_cycles($past(q.rate)) - 1'b1))
      else $error("acquisition length wrong");

   conv_start_a: assert property ( // R10
      (ce && !abort && q.adc_on && (q.st == adc_seq_pkg::S_ACQ) && (q.cnt == '0))
      |=> (q.st == adc_seq_pkg::S_CONV) && (q.cnt == adc_seq_pkg::CONV_CYC - 1'b1))
      else $error("conversion length wrong");

   // result buffering and reads
   hold_capture_a: assert property ( // R8
      (ce && (q.st == adc_seq_pkg::S_CONV) && (q.cnt == '0))
      |=> (q.tmpry[$past(q.ch)] == $past(conv_data)))
      else $error("holding stage missed result");

   copy_all_a: assert property ( // R8
      (ce && do_copy) |=> (q.data == $past(q.tmpry)))
      else $error("results not copied together");

   result_read_a: assert property ( // R7
      (ce && rd_data)
      |=> (rdata[adc_seq_pkg::RES_W-1:0] == $past(q.data[bus_req.addr[adc_seq_pkg::CH_W-1:0]])))
      else $error("result read wrong");

   rdata_idle_a: assert property ( // R7
      (ce && !bus_req.re) |=> (rdata == '0))
      else $error("read data outside read cycle");

   trig_zero_a: assert property ( // R18
      (ce && bus_req.re && (bus_req.addr == adc_seq_pkg::CFG_ADDR))
      |=> !rdata[adc_seq_pkg::TRIG_BIT])
      else $error("trigger bit read nonzero");

   ready_hold_a: assert property ( // R16
      (ce && q.ready && !rd_data && !trig) |=> q.ready)
      else $error("ready dropped by itself");

   // nap and temperature
   nap_fast_a: assert property ( // R11
      (q.rate == 2'h0) |-> !adc_ctl.nap)
      else $error("nap at fastest rate");

   nap_conv_a: assert property ( // R11
      adc_ctl.convert |-> !adc_ctl.nap)
      else $error("nap during conversion");

   temp_capture_a: assert property ( // R21
      (ce && q.temp_en && q.temp_run && temp_done) |=> (q.temp_hold == $past(temp_code)))
      else $error("temperature result not captured");

   temp_copy_a: assert property ( // R22
      (ce && q.temp_pend && !temp_shift_busy) |=> (q.temp_data == $past(q.temp_hold)))
      else $error("temperature result not copied");
endmodule : adc_sequencer

// [adc_seq_pkg.sv]
// constants, register map and types of the adc sequencer and temperature monitor
package adc_seq_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int NCH = 8;
   localparam int CH_W = 3;
   localparam int RES_W = 10;
   localparam int TEMP_W = 12;
   localparam int CNT_W = 16;

   // register word addresses
   localparam logic [ADDR_W-1:0] CFG_ADDR = 8'h00;
   localparam logic [ADDR_W-1:0] EN_ADDR = 8'h01;
   localparam logic [ADDR_W-1:0] PWR_ADDR = 8'h02;
   localparam logic [ADDR_W-1:0] TCFG_ADDR = 8'h03;
   localparam logic [ADDR_W-1:0] TDATA_ADDR = 8'h04;
   localparam logic [ADDR_W-1:0] DATA_BASE = 8'h10;

   // field positions
   localparam int TRIG_BIT = 15;
   localparam int MODE_BIT = 13;
   localparam int RATE_LO = 8;
   localparam int READY_BIT = 7;
   localparam int PIN_BIT = 6;
   localparam int ADC_ON_BIT = 14;
   localparam int TEMP_EN_BIT = 3;

   // reset values, and the mode code of direct style
   localparam logic MODE_RST = 1'b1;
   localparam logic [1:0] RATE_RST = 2'h0;
   localparam logic [NCH-1:0] EN_RST = 8'h00;
   localparam logic ADC_ON_RST = 1'b0;
   localparam logic TEMP_EN_RST = 1'b1;
   localparam logic MODE_DIRECT = 1'b0;

   // timing in ns, and derived cycle counts
   localparam int CLK_PERIOD_NS = 10;
   localparam int TACQ0_NS = 375;
   localparam int TACQ1_NS = 2375;
   localparam int TACQ2_NS = 6375;
   localparam int TACQ3_NS = 14375;
   localparam int TCONV_NS = 1625;
   localparam int TSYNC_NS = 4000;
   localparam int TPULSE_NS = 1000;
   localparam logic [CNT_W-1:0] ACQ0_CYC = CNT_W'((TACQ0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] ACQ1_CYC = CNT_W'((TACQ1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] ACQ2_CYC = CNT_W'((TACQ2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] ACQ3_CYC = CNT_W'((TACQ3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] CONV_CYC = CNT_W'((TCONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] SYNC_CYC = CNT_W'(TSYNC_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] PULSE_CYC = CNT_W'(TPULSE_NS / CLK_PERIOD_NS);

   typedef enum logic [1:0] {S_WAIT, S_SYNC, S_ACQ, S_CONV} seq_state_t;

   typedef struct packed {
      logic we;
      logic re;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic pd;
      logic nap;
      logic track;
      logic convert;
      logic [CH_W-1:0] ch;
   } adc_ctl_t;

   typedef struct packed {
      seq_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [CH_W-1:0] ch;
      logic mode;
      logic [1:0] rate;
      logic [NCH-1:0] en;
      logic adc_on;
      logic temp_en;
      logic ready;
      logic [CNT_W-1:0] pulse_cnt;
      logic [NCH-1:0][RES_W-1:0] tmpry;
      logic [NCH-1:0][RES_W-1:0] data;
      logic copy_pend;
      logic temp_run;
      logic temp_start;
      logic temp_pend;
      logic [TEMP_W-1:0] temp_hold;
      logic [TEMP_W-1:0] temp_data;
      logic [DATA_W-1:0] rdata;
   } state_t;

   localparam state_t ST_RST = '{st: S_WAIT, mode: MODE_RST, rate: RATE_RST, en: EN_RST,
                                 adc_on: ADC_ON_RST, temp_en: TEMP_EN_RST, default: '0};
endpackage : adc_seq_pkg

// [adc_far_model.sv]
// stand-in for the sar converter and the temperature adc behind the sequencer
`timescale 1ns/1ns
module adc_far_model (
   input wire logic clk, // 100 MHz clock
   input wire logic rst, // asynchronous reset, active high
   input wire adc_seq_pkg::adc_ctl_t adc_ctl, // converter control from the sequencer
   input wire logic [6:0] base, // low bits of every sample
   input wire logic temp_start, // start one temperature conversion
   output logic [adc_seq_pkg::RES_W-1:0] conv_data, // sample of the selected channel
   output logic temp_done, // temperature result ready, one cycle
   output logic [adc_seq_pkg::TEMP_W-1:0] temp_code // temperature result
);
   int tcnt;
   // the sample only holds during convert; otherwise it shows a wrong value on purpose
   assign conv_data = adc_ctl.convert ? {adc_ctl.ch, base} : ~{adc_ctl.ch, base};
   // +25 degrees while done, inverted otherwise
   assign temp_code = temp_done ? 12'h0c8 : 12'hf37;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tcnt <= 0;
         temp_done <= 1'b0;
      end else begin
         temp_done <= (tcnt == 1);
         if (temp_start) begin
            tcnt <= 50;
         end else if (tcnt > 0) begin
            tcnt <= tcnt - 1;
         end
      end
   end
endmodule : adc_far_model

// [adc_sequencer_test.sv]
// self-checking bench of the adc sequencer
`timescale 1ns/1ns
module adc_sequencer_test;
   logic clk;
   logic rst;
   logic ce;
   adc_seq_pkg::bus_req_t bus_req;
   logic [adc_seq_pkg::DATA_W-1:0] rdata;
   logic [adc_seq_pkg::RES_W-1:0] conv_data;
   adc_seq_pkg::adc_ctl_t adc_ctl;
   logic adc_shift_busy;
   logic temp_shift_busy;
   logic temp_start;
   logic temp_done;
   logic [adc_seq_pkg::TEMP_W-1:0] temp_code;
   logic data_valid_n_o;
   logic data_valid_n_oe;
   logic data_valid_n_pin;
   logic [6:0] base;
   logic re_d;
   logic got;
   int fails;
   int compares;
   int seed;
   int n;
   logic [15:0] expq[$];

   // external pull-up on the open-drain line
   assign data_valid_n_pin = data_valid_n_oe ? data_valid_n_o : 1'b1;

   adc_sequencer uut (.clk(clk), .rst(rst), .ce(ce), .bus_req(bus_req), .rdata(rdata),
      .conv_data(conv_data), .adc_ctl(adc_ctl), .adc_shift_busy(adc_shift_busy),
      .temp_shift_busy(temp_shift_busy), .temp_start(temp_start), .temp_done(temp_done),
      .temp_code(temp_code), .data_valid_n_i(data_valid_n_pin),
      .data_valid_n_o(data_valid_n_o), .data_valid_n_oe(data_valid_n_oe));

   adc_far_model far (.clk(clk), .rst(rst), .adc_ctl(adc_ctl), .base(base),
      .temp_start(temp_start), .conv_data(conv_data), .temp_done(temp_done),
      .temp_code(temp_code));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      bus_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus_req.we <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      expq.push_back(e);
      @(posedge clk);
      bus_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk);
      bus_req.re <= 1'b0;
   endtask : rd

   task automatic wait_oe(input int lim, output logic hit);
      hit = 1'b0;
      for (int i = 0; i < lim && !hit; i++) begin
         @(posedge clk);
         #1 hit = (data_valid_n_oe === 1'b1);
      end
   endtask : wait_oe

   // read data stand in the cycle after the strobe only
   always @(posedge clk) re_d <= bus_req.re;
   always @(negedge clk) begin
      if (re_d === 1'b1) begin
         if (expq.size() == 0) check(rdata, 16'hxxxx);
         else check(rdata, expq.pop_front());
      end
   end

   initial begin
      #600000;
      fails++;
      give_verdict();
   end

   initial begin
      seed = 17145;
      fails = 0;
      compares = 0;
      ce = 1'b1;
      rst = 1'b1;
      bus_req = '0;
      adc_shift_busy = 1'b0;
      temp_shift_busy = 1'b0;
      base = 7'($random(seed));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(adc_seq_pkg::CFG_ADDR, 16'h2040);
      rd(adc_seq_pkg::EN_ADDR, 16'h0000);
      rd(adc_seq_pkg::PWR_ADDR, 16'h0000);
      rd(adc_seq_pkg::TCFG_ADDR, 16'h0008);
      rd(8'h20, 16'h0000);
      repeat (100) @(posedge clk);
      rd(adc_seq_pkg::TDATA_ADDR, 16'h00c8);
      wr(adc_seq_pkg::TCFG_ADDR, 16'h0000);
      repeat (60) @(posedge clk);
      n = 0;
      repeat (200) begin
         @(posedge clk);
         #1 if (temp_start === 1'b1) n++;
      end
      check(n[15:0], 16'h0000);
      wr(adc_seq_pkg::TCFG_ADDR, 16'h0008);
      n = 0;
      repeat (200) begin
         @(posedge clk);
         #1 if (temp_start === 1'b1) n++;
      end
      check({15'h0000, n >= 2}, 16'h0001);
      // direct style, channels 0 and 2
      wr(adc_seq_pkg::PWR_ADDR, 16'h4000);
      wr(adc_seq_pkg::EN_ADDR, 16'h0005);
      wr(adc_seq_pkg::CFG_ADDR, 16'h0000);
      wr(adc_seq_pkg::CFG_ADDR, 16'h8000);
      wait_oe(2000, got);
      check({15'h0000, got}, 16'h0001);
      rd(adc_seq_pkg::CFG_ADDR, 16'h0080);
      for (int c = 0; c < 8; c++) begin
         rd(8'(adc_seq_pkg::DATA_BASE + c),
            (c == 0 || c == 2) ? {6'h00, 3'(c), base} : 16'h0000);
      end
      check({15'h0000, data_valid_n_oe}, 16'h0000);
      // slower rate naps and still completes
      wr(adc_seq_pkg::CFG_ADDR, 16'h0100);
      wr(adc_seq_pkg::CFG_ADDR, 16'h8100);
      repeat (10) @(posedge clk);
      #1 check({15'h0000, adc_ctl.nap}, 16'h0001);
      wait_oe(3000, got);
      check({15'h0000, got}, 16'h0001);
      wr(adc_seq_pkg::CFG_ADDR, 16'h8100);
      repeat (2) @(posedge clk);
      #1 check({15'h0000, data_valid_n_oe}, 16'h0000);
      // enable rewrite during the sync delay leaves it waiting
      repeat (20) @(posedge clk);
      wr(adc_seq_pkg::EN_ADDR, 16'h0005);
      wait_oe(2000, got);
      check({15'h0000, got}, 16'h0000);
      // auto style pulses data-valid and restarts by itself
      wr(adc_seq_pkg::CFG_ADDR, 16'h2000);
      wr(adc_seq_pkg::CFG_ADDR, 16'ha000);
      wait_oe(2000, got);
      check({15'h0000, got}, 16'h0001);
      n = 0;
      while (data_valid_n_oe === 1'b1 && n < 200) begin
         @(posedge clk);
         #1 n++;
      end
      check(n[15:0], 16'd100);
      wait_oe(2000, got);
      check({15'h0000, got}, 16'h0001);
      rd(adc_seq_pkg::CFG_ADDR, 16'h2000);
      // host shifts results out only after the pulse; the update waits until the shift ends
      repeat (120) @(posedge clk);
      adc_shift_busy <= 1'b1;
      wait_oe(900, got);
      check({15'h0000, got}, 16'h0000);
      adc_shift_busy <= 1'b0;
      wait_oe(5, got);
      check({15'h0000, got}, 16'h0001);
      repeat (3) @(posedge clk);
      give_verdict();
   end
endmodule : adc_sequencer_test
